/* File: shared/mhss_pkg.sv */
// package for the host spi slave port: constants, carriers and the state layout
`default_nettype none

package mhss_pkg;

	localparam int WORD_BITS  = 8;
	localparam int CNT_W      = 3;
	localparam int FIFO_DEPTH = 4;

	localparam logic [CNT_W-1:0]     CNT_ZERO  = 3'h0;
	localparam logic [CNT_W-1:0]     CNT_ONE   = 3'h1;
	localparam logic [CNT_W-1:0]     CNT_LAST  = 3'h7;
	localparam logic [WORD_BITS-1:0] TX_FILLER = 8'hFF;
	localparam logic [WORD_BITS-1:0] BYTE_RST  = 8'h00;
	localparam int                   MSB       = WORD_BITS - 1;

	// host-side clock limit; only the host is bound by it, no check uses it
	localparam int CLK_PERIOD_PS    = 4000;
	localparam int SCK_MAX_KHZ      = 5182;
	localparam int SCK_HALF_DIV     = 2 * SCK_MAX_KHZ * CLK_PERIOD_PS;
	localparam int SCK_MIN_HALF_CYC = (1000000000 + SCK_HALF_DIV - 1) / SCK_HALF_DIV;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic din;
	} mhss_pins_s;

	localparam mhss_pins_s PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};

	typedef struct packed {
		mhss_pins_s             s1;
		mhss_pins_s             s2;
		mhss_pins_s             s3;
		logic                   active;
		logic [CNT_W-1:0]       rx_cnt;
		logic [WORD_BITS-1:0]   rx_sh;
		logic [CNT_W-1:0]       tx_cnt;
		logic [WORD_BITS-1:0]   tx_sh;
		logic                   dout;
		logic                   oe_n;
		logic                   push;
		logic [WORD_BITS-1:0]   push_data;
		logic                   overflow;
		logic                   tx_taken;
		logic                   underrun;
		logic                   frame_end;
		logic                   partial;
	} mhss_state_s;

	localparam mhss_state_s STATE_RST = '{
		s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE,
		active: 1'b0,
		rx_cnt: CNT_ZERO, rx_sh: BYTE_RST,
		tx_cnt: CNT_ZERO, tx_sh: BYTE_RST,
		dout: 1'b0, oe_n: 1'b1,
		push: 1'b0, push_data: BYTE_RST,
		overflow: 1'b0, tx_taken: 1'b0, underrun: 1'b0,
		frame_end: 1'b0, partial: 1'b0
	};

endpackage : mhss_pkg

`default_nettype wire

/* File: rtl/mhss_fifo.sv */
// small shift-style fifo; the head word always sits in a flip-flop
`default_nettype none

module mhss_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);

	localparam int CW = $clog2(D + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(D);
	localparam logic [CW-1:0] CNT_ONE  = CW'(1);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [CW-1:0]       cnt;
		logic                valid;
	} mhss_fifo_s;

	mhss_fifo_s q;
	mhss_fifo_s n;
	logic       pop;
	logic       push;

	// full is honest: no write-through while full, so the filler sees the stall
	assign in_ready  = (q.cnt != CNT_FULL);
	assign out_valid = q.valid;
	assign out_data  = q.mem[0];

	always_comb begin
		n    = q;
		pop  = q.valid && out_ready;
		push = in_valid && in_ready;
		if (pop) begin
			for (int i = 0; i < D - 1; i++) begin
				n.mem[i] = q.mem[i + 1];
			end
			n.cnt = q.cnt - CNT_ONE;
		end
		if (push) begin
			n.mem[pop ? q.cnt - CNT_ONE : q.cnt] = in_data;
			n.cnt = n.cnt + CNT_ONE;
		end
		n.valid = (n.cnt != '0);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

endmodule // mhss_fifo

`default_nettype wire

/* File: rtl/mhss_spi_slave.sv */
// host spi slave port: pin sampling, byte shifters and receive buffering
`default_nettype none

module mhss_spi_slave (
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	input  wire logic                          serial_clock_pin,
	input  wire logic                          slave_select_pin_n,
	input  wire logic                          serial_in_pin,
	output logic                               serial_out_pin,
	output logic                               serial_out_oe_n,
	input  wire logic                          uart_selected,
	input  wire logic                          tx_valid,
	input  wire logic [mhss_pkg::WORD_BITS-1:0] tx_data,
	output logic                               tx_taken,
	output logic                               tx_underrun,
	output logic                               rx_valid,
	output logic [mhss_pkg::WORD_BITS-1:0]     rx_data,
	input  wire logic                          rx_ready,
	output logic                               rx_overflow,
	output logic                               frame_end,
	output logic                               frame_partial,
	output logic                               spi_active
);

	mhss_pkg::mhss_state_s            q;
	mhss_pkg::mhss_state_s            n;
	logic                             fifo_in_ready;
	logic                             in_frame;
	logic                             rise;
	logic                             fall;
	logic                             sel_release;
	logic [mhss_pkg::WORD_BITS-1:0]   rx_word;
	logic [mhss_pkg::WORD_BITS-1:0]   tx_word;
	logic                             first_bit_h;

	// edges are found from the synchronised copies only, so the period and any
	// gaps between edges do not matter as long as each level lasts a few clocks
	assign rise        = q.s2.sclk && !q.s3.sclk;
	assign fall        = !q.s2.sclk && q.s3.sclk;
	assign in_frame    = q.active && !q.s2.cs_n;
	assign sel_release = q.s2.cs_n && !q.s3.cs_n;
	assign rx_word     = {q.rx_sh[mhss_pkg::MSB-1:0], q.s2.din};
	assign tx_word     = tx_valid ? tx_data : mhss_pkg::TX_FILLER;
	assign first_bit_h = tx_word[mhss_pkg::MSB];

	always_comb begin
		n           = q;
		// three sampling stages; only the second stage reads the first
		n.s1        = '{sclk: serial_clock_pin, cs_n: slave_select_pin_n,
		                din: serial_in_pin};
		n.s2        = q.s1;
		n.s3        = q.s2;
		n.active    = !uart_selected;
		n.push      = 1'b0;
		n.tx_taken  = 1'b0;
		n.underrun  = 1'b0;
		n.frame_end = q.active && sel_release;
		// a frame that ends mid-word drops the stray bits and says so
		n.partial   = q.active && sel_release && (q.rx_cnt != mhss_pkg::CNT_ZERO);
		// no room in the buffer: the word is lost and the command layer must
		// ask for the message again
		n.overflow  = q.push && !fifo_in_ready;
		if (!in_frame) begin
			// idle: clock edges ignored, counters rewound for the next select
			n.rx_cnt = mhss_pkg::CNT_ZERO;
			n.tx_cnt = mhss_pkg::CNT_ZERO;
			n.oe_n   = 1'b1;
			n.dout   = 1'b0;
		end else begin
			n.oe_n = 1'b0;
			if (fall) begin
				n.rx_sh  = rx_word;
				n.rx_cnt = q.rx_cnt + mhss_pkg::CNT_ONE;
				if (q.rx_cnt == mhss_pkg::CNT_LAST) begin
					n.push      = 1'b1;
					n.push_data = rx_word;
				end
			end
			if (rise) begin
				n.tx_cnt = q.tx_cnt + mhss_pkg::CNT_ONE;
				if (q.tx_cnt == mhss_pkg::CNT_ZERO) begin
					// word boundary: take the next word, or send filler if none
					n.dout     = tx_word[mhss_pkg::MSB];
					n.tx_sh    = {tx_word[mhss_pkg::MSB-1:0], 1'b0};
					n.tx_taken = tx_valid;
					n.underrun = !tx_valid;
				end else begin
					n.dout  = q.tx_sh[mhss_pkg::MSB];
					n.tx_sh = {q.tx_sh[mhss_pkg::MSB-1:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= mhss_pkg::STATE_RST;
		end else begin
			q <= n;
		end
	end

	// the host cannot be stalled, so back-pressure ends in the overflow flag
	mhss_fifo #(
		.W (mhss_pkg::WORD_BITS),
		.D (mhss_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (q.push),
		.in_data   (q.push_data),
		.in_ready  (fifo_in_ready),
		.out_valid (rx_valid),
		.out_data  (rx_data),
		.out_ready (rx_ready)
	);

	assign serial_out_pin  = q.dout;
	assign serial_out_oe_n = q.oe_n;
	assign tx_taken        = q.tx_taken;
	assign tx_underrun     = q.underrun;
	assign rx_overflow     = q.overflow;
	assign frame_end       = q.frame_end;
	assign frame_partial   = q.partial;
	assign spi_active      = q.active;

	// the output driver is only ever on inside a selected frame
	drive_in_frame_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		!q.oe_n |-> $past(in_frame)
	) else $error("output driven outside a selected frame");

	uart_exclusive_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		uart_selected |-> ##2 (serial_out_oe_n && !spi_active)
	) else $error("spi port still active with uart selected");

	idle_release_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(q.s2.cs_n && !fall && !rise) |=> (q.oe_n && q.rx_cnt == mhss_pkg::CNT_ZERO
		                                   && q.tx_cnt == mhss_pkg::CNT_ZERO)
	) else $error("idle select did not release output or rewind counters");

	sample_on_fall_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(in_frame && fall) |=> (q.rx_sh[0] == $past(q.s2.din)
		                        && q.rx_cnt == $past(q.rx_cnt) + mhss_pkg::CNT_ONE)
	) else $error("input bit not sampled on falling edge");

	hold_between_rise_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(in_frame && !rise) ##1 in_frame |-> $stable(q.dout)
	) else $error("output changed away from a rising edge");

	eighth_bit_push_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(in_frame && fall && q.rx_cnt == mhss_pkg::CNT_LAST) |=>
			(q.push && q.push_data == q.rx_sh)
	) else $error("eighth bit did not deliver a word");

	msb_leads_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(in_frame && rise && q.tx_cnt == mhss_pkg::CNT_ZERO) |=>
			(q.dout == $past(first_bit_h) && (q.tx_taken || q.underrun))
	) else $error("word boundary did not send most significant bit");

	overflow_flag_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(q.push && !fifo_in_ready) |=> rx_overflow ##1 !rx_overflow
	) else $error("lost word not flagged as overflow");

	take_single_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		tx_taken |=> !tx_taken
	) else $error("transmit word taken twice in a row");

endmodule // mhss_spi_slave

`default_nettype wire

/* File: bench/mhss_host_model.sv */
// host master model for the spi slave port: drives clock, select and data in
`default_nettype none

module mhss_host_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] to_dev[$];
	logic [7:0] from_dev[$];

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din  = 1'b1;
	end

	// clock idles low and toggles only inside a frame; only this side makes it
	// half periods of 62.5 ns run the link faster than the host limit on purpose,
	// to stress the sampler; a real host stays at or below it
	task automatic frame(input int nbits);
		logic [7:0] b;
		logic [7:0] r;
		b = 8'h00;
		r = 8'h00;
		cs_n = 1'b0;
		#200;
		for (int i = 0; i < nbits; i++) begin
			if (i % 8 == 0) b = to_dev.pop_front();
			sclk = 1'b1;
			din  = b[7 - i % 8];
			#62.5;
			sclk = 1'b0;
			r = {r[6:0], dout};
			#62.5;
			if (i % 8 == 7) begin
				from_dev.push_back(r);
				din = ~din;
				#250; // pause between words so the device keeps up
			end
		end
		din = ~din;
		#100;
		cs_n = 1'b1;
		#200;
	endtask
endmodule // mhss_host_model

`default_nettype wire

/* File: bench/module_host_spi_slave_bench.sv */
// self-checking bench for the host spi slave port
`default_nettype none

module module_host_spi_slave_bench;
	timeunit 1ns;
	timeprecision 100ps;

	logic       clk, reset_n, sclk, cs_n, din, dout, oe_n, uart_sel, rx_ready;
	logic       tx_valid, tx_taken, tx_under, rx_valid, rx_ovf, f_end, f_part, act;
	logic [7:0] tx_data, rx_data;
	logic [7:0] got[$], txq[$], sent[$], exp_tx[$];
	logic [31:0] seed = 32'hF3F1;
	int n_mismatch, checks_done, cycles, n_taken, n_under, n_ovf, n_end, n_part, n_drive;

	mhss_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
	mhss_spi_slave uut (.clk(clk), .reset_n(reset_n), .serial_clock_pin(sclk),
		.slave_select_pin_n(cs_n), .serial_in_pin(din), .serial_out_pin(dout),
		.serial_out_oe_n(oe_n), .uart_selected(uart_sel), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_taken(tx_taken), .tx_underrun(tx_under),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.rx_overflow(rx_ovf), .frame_end(f_end), .frame_partial(f_part),
		.spi_active(act));

	initial clk = 1'b0;
	always #2 clk = ~clk;

	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t byte %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_n(input int g, input int e);
		checks_done++;
		if (g != e) begin
			n_mismatch++;
			$display("MISMATCH %0t count %0d expected %0d", $time, g, e);
		end
	endtask

	// the next word is offered only after the previous one was taken
	always @(negedge clk) begin
		tx_valid <= txq.size() != 0;
		tx_data  <= (txq.size() != 0) ? txq[0] : 8'h00;
	end

	always @(posedge clk) begin
		cycles++;
		if (tx_taken === 1'b1) void'(txq.pop_front());
		n_taken += (tx_taken === 1'b1);
		n_under += (tx_under === 1'b1);
		n_ovf   += (rx_ovf === 1'b1);
		n_end   += (f_end === 1'b1);
		n_part  += (f_part === 1'b1);
		n_drive += (uart_sel && oe_n !== 1'b1);
		if (rx_valid === 1'b1 && rx_ready) got.push_back(rx_data);
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end

	// one frame of nb words, the first ntx of them offered for sending
	task automatic burst(input int nb, input int ntx, input logic [7:0] corner);
		logic [7:0] b;
		sent.delete();
		exp_tx.delete();
		host.from_dev.delete();
		for (int i = 0; i < nb; i++) begin
			b = (i == 0) ? corner : rnd();
			sent.push_back(b);
			host.to_dev.push_back(b);
			b = (i == 0) ? ~corner : rnd();
			exp_tx.push_back((i < ntx) ? b : 8'hFF);
			if (i < ntx) txq.push_back(b);
		end
		host.frame(nb * 8);
		for (int i = 0; i < nb; i++) chk8(host.from_dev[i], exp_tx[i]);
		chk8({6'h00, oe_n, dout}, 8'h02);
	endtask

	initial begin
		reset_n  = 1'b0;
		uart_sel = 1'b0;
		rx_ready = 1'b1;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (10) @(negedge clk);
		chk8({7'h00, act}, 8'h01);
		burst(4, 3, 8'h80);
		for (int i = 0; i < 4; i++) chk8(got[i], sent[i]);
		chk_n(n_taken, 3);
		chk_n(n_under, 1);
		chk_n(n_end, 1);
		got.delete();
		@(negedge clk);
		rx_ready = 1'b0;
		burst(5, 0, 8'h01);
		chk_n(n_ovf, 1);
		chk_n(n_under, 6);
		@(negedge clk);
		rx_ready = 1'b1;
		repeat (10) @(negedge clk);
		chk_n(got.size(), 4);
		for (int i = 0; i < 4; i++) chk8(got[i], sent[i]);
		got.delete();
		host.to_dev.push_back(8'hA5);
		host.frame(3);
		chk_n(n_part, 1);
		chk_n(n_end, 3);
		chk_n(got.size(), 0);
		@(negedge clk);
		uart_sel = 1'b1;
		repeat (5) @(negedge clk);
		chk8({7'h00, act}, 8'h00);
		host.to_dev.push_back(8'h3C);
		host.frame(8);
		chk_n(got.size(), 0);
		chk_n(n_end, 3);
		chk_n(n_drive, 0);
		@(negedge clk);
		uart_sel = 1'b0;
		close_out();
	end
endmodule // module_host_spi_slave_bench

`default_nettype wire
